// [debug_trigger_control_bench.sv]
// Self-checking bench for the debug trigger control block
`timescale 1ns/1ns
module debug_trigger_control_bench;
    import dtc_pkg::*;
    localparam int DEPTH = 4;
    logic         i_clk = 1'h0;
    logic         i_srst = 1'h1;
    logic         sec = 1'h0;
    logic         fclr = 1'h1;
    logic         ce = 1'h1;
    logic         full;
    logic         irq;
    logic [7:0]   wrs, tags, frcs;
    dtc_ahb_req_t ahb = {1'h1, 32'h0, 2'h0, 1'h0, 3'h2, 1'h1, 32'h0};
    dtc_ahb_rsp_t rsp;
    dtc_mon_t     mon = '0;
    dtc_cpu_t     cpu;
    int           miscompares = 0;
    int           checks = 0;
    int           cycles = 0;
    always #20 i_clk = ~i_clk;
    dtc_debug_trigger_control uut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(ce),
        .i_ahb(ahb), .o_ahb(rsp), .i_secure(sec), .i_mon({mon[7:1], full}),
        .o_cpu(cpu), .o_irq(irq));
    dtc_cpu_model #(.DEPTH(DEPTH)) far (.i_clk(i_clk), .i_clr(fclr), .i_cpu(cpu),
        .o_full(full), .o_wrs(wrs), .o_tags(tags), .o_forces(frcs));
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    // Single word transfer; address phase always gets one idle cycle ahead of it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge i_clk);
        ahb.haddr <= {24'h0, a};
        ahb.hwrite <= w;
        ahb.htrans <= 2'h2;
        do @(posedge i_clk); while (rsp.hreadyout !== 1'h1);
        ahb.htrans <= 2'h0;
        ahb.hwdata <= d;
        do @(posedge i_clk); while (rsp.hreadyout !== 1'h1);
        q = rsp.hrdata;
    endtask : xfer
    task automatic hit(input logic rd, input logic [1:0] ts, output logic [2:0] c);
        @(posedge i_clk);
        mon <= {1'h1, rd, ts != 2'h3, ts != 2'h0, ts, 1'h0, 1'h0};
        @(posedge i_clk);
        mon.valid <= 1'h0;
        #1 c = {cpu.fifo_wr, cpu.brk_tag, cpu.brk_force};
    endtask : hit
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] q;
        xfer(1'h0, DTC_OFS_CTRL, 32'h0, q);
        cmp(q, {24'h0, DTC_CTRL_RST});
        xfer(1'h1, DTC_OFS_CTRL, 32'h2f, q);
        xfer(1'h0, DTC_OFS_CTRL, 32'h0, q);
        cmp(q, 32'h2f);
        xfer(1'h0, 8'h40, 32'h0, q);
        cmp(q, 32'h0);
    endtask : t_regs
    task automatic t_secure;
        logic [31:0] q;
        sec <= 1'h1;
        xfer(1'h1, DTC_OFS_CTRL, 32'hbf, q);
        xfer(1'h0, DTC_OFS_CTRL, 32'h0, q);
        cmp(q & 32'h80, 32'h0);
        sec <= 1'h0;
    endtask : t_secure
    task automatic t_end(input logic tg);
        logic [31:0] q;
        logic [2:0]  c;
        xfer(1'h1, DTC_OFS_CTRL, {24'h0, 2'h3, tg, 5'h10}, q);
        xfer(1'h0, DTC_OFS_STATUS, 32'h0, q);
        cmp(q & 32'h1, 32'h1);
        hit(1'h0, DTC_TRG_A, c);
        cmp({29'h0, c}, {29'h0, 1'h1, tg, !tg});
        xfer(1'h0, DTC_OFS_CTRL, 32'h0, q);
        cmp(q, {24'h0, 2'h2, tg, 5'h10});
    endtask : t_end
    // Earlier runs left events pending, so the first look shows them masked
    task automatic t_irq;
        logic [31:0] q;
        logic [2:0]  c;
        xfer(1'h0, DTC_OFS_IRQ_STS, 32'h0, q);
        cmp({q[30:0], irq}, 32'h6);
        xfer(1'h1, DTC_OFS_IRQ_CLR, 32'h3, q);
        xfer(1'h0, DTC_OFS_IRQ_STS, 32'h0, q);
        cmp({q[30:0], irq}, 32'h0);
        xfer(1'h1, DTC_OFS_IRQ_EN, 32'h1, q);
        xfer(1'h1, DTC_OFS_CTRL, 32'hd0, q);
        hit(1'h0, DTC_TRG_A, c);
        xfer(1'h0, DTC_OFS_IRQ_STS, 32'h0, q);
        cmp({q[30:0], irq}, 32'h7);
        xfer(1'h1, DTC_OFS_IRQ_EN, 32'h0, q);
        xfer(1'h0, DTC_OFS_IRQ_STS, 32'h0, q);
        cmp({q[30:0], irq}, 32'h6);
    endtask : t_irq
    task automatic t_nobrk;
        logic [31:0] q;
        logic [2:0]  c;
        xfer(1'h1, DTC_OFS_CTRL, 32'he0, q);
        hit(1'h0, DTC_TRG_A, c);
        cmp({29'h0, c}, 32'h4);
    endtask : t_nobrk
    task automatic t_dir;
        logic [31:0] q;
        logic [2:0]  c;
        for (int i = 0; i < 16; i++) begin
            xfer(1'h1, DTC_OFS_CTRL, i[3] ? {24'h0, 6'h30, i[1], i[2]}
                                          : {24'h0, 4'hc, i[1], i[2], 2'h0}, q);
            hit(i[0], i[3] ? DTC_TRG_B : DTC_TRG_A, c);
            cmp({31'h0, c[2]}, {31'h0, !i[2] || (i[1] == i[0])});
        end
    endtask : t_dir
    task automatic t_stop;
        logic [31:0] q;
        logic [2:0]  c;
        for (int i = 0; i < 2; i++) begin
            xfer(1'h1, DTC_OFS_CTRL, 32'hc0, q);
            xfer(1'h1, DTC_OFS_CTRL, (i == 0) ? 32'h40 : 32'h80, q);
            hit(1'h0, DTC_TRG_A, c);
            cmp({29'h0, c}, 32'h0);
        end
    endtask : t_stop
    // Clock enable low must freeze the armed sequencer, not lose the run
    task automatic t_ce;
        logic [31:0] q;
        logic [2:0]  c;
        xfer(1'h1, DTC_OFS_CTRL, 32'hc0, q);
        ce <= 1'h0;
        hit(1'h0, DTC_TRG_A, c);
        cmp({29'h0, c}, 32'h0);
        ce <= 1'h1;
        hit(1'h0, DTC_TRG_A, c);
        cmp({29'h0, c}, 32'h4);
    endtask : t_ce
    task automatic t_begin;
        logic [31:0] q;
        for (int i = 0; i < 2; i++) begin
            xfer(1'h1, DTC_OFS_CTRL, 32'hd0, q);
            fclr <= 1'h0;
            @(posedge i_clk);
            mon <= {3'h5, i[0], i[0] ? DTC_TRG_A_OR_B : DTC_TRG_A, 2'h2};
            for (int n = 0; n < 60 && frcs == 8'h0; n++) @(posedge i_clk);
            mon <= '0;
            cmp({8'h0, wrs, tags, frcs}, {8'h0, 8'(DEPTH), 8'h0, 8'h1});
            fclr <= 1'h1;
        end
    endtask : t_begin
    ////////////////////////////////////////////////////////////////////////////
    // Whole run is about two hundred cycles; the ceiling only catches a hang
    always @(posedge i_clk) begin
        cycles++;
        if (cycles > 5000) begin
            miscompares++;
            $display("unexpected at %0t: run hung", $time);
            report_and_stop;
        end
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_srst <= 1'h0;
        t_regs;
        t_secure;
        t_end(1'h1);
        t_end(1'h0);
        t_irq;
        t_nobrk;
        t_dir;
        t_stop;
        t_ce;
        t_begin;
        report_and_stop;
    end
endmodule : debug_trigger_control_bench

// [dtc_assertions.sv]
// Port checker for the debug trigger control block
`timescale 1ns/1ns
module dtc_assertions (
    input wire logic                  i_clk,
    input wire logic                  i_srst,
    input wire logic                  i_ce,
    input wire dtc_pkg::dtc_ahb_req_t i_ahb,
    input wire dtc_pkg::dtc_ahb_rsp_t o_ahb,
    input wire dtc_pkg::dtc_mon_t     i_mon,
    input wire dtc_pkg::dtc_cpu_t     o_cpu,
    input wire logic                  o_irq
);
    import dtc_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic brk;
    logic rd_take;
    assign brk = o_cpu.brk_tag | o_cpu.brk_force;
    assign rd_take = i_ce & i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1] & ~i_ahb.hwrite;
    bus_ok_a: assert property (o_ahb.hreadyout && !o_ahb.hresp)
        else $error("bus stalled or errored");
    rdata_idle_a: assert property (!$past(rd_take) |-> o_ahb.hrdata == 32'h0)
        else $error("read data outside data phase");
    reset_quiet_a: assert property (disable iff (1'h0)
        i_srst |=> !o_irq && !brk && !o_cpu.fifo_wr) else $error("activity after reset");
    store_cause_a: assert property (o_cpu.fifo_wr |-> $past(i_mon.valid))
        else $error("store without bus cycle");
    break_kind_a: assert property (!(o_cpu.brk_tag && o_cpu.brk_force))
        else $error("tag and force together");
    end_break_a: assert property (brk && !$past(i_mon.begin_trace) |-> o_cpu.fifo_wr)
        else $error("end trace break without store");
    begin_break_a: assert property (brk && $past(i_mon.begin_trace)
        |-> $past(i_mon.fifo_full) && !o_cpu.fifo_wr) else $error("begin break not at full");
    run_end_a: assert property (brk |=> (!brk && !o_cpu.fifo_wr) [*3])
        else $error("activity after run end");
    cover property (o_cpu.brk_tag);
    cover property (o_cpu.brk_force);
    cover property (o_cpu.fifo_wr && !brk);
    cover property (o_irq);
endmodule : dtc_assertions
bind dtc_debug_trigger_control dtc_assertions chk (
    .i_clk, .i_srst, .i_ce, .i_ahb, .o_ahb, .i_mon, .o_cpu, .o_irq);

// [dtc_cpu_model.sv]
// Far side model: trace FIFO fill level and CPU break request counts
`timescale 1ns/1ns
module dtc_cpu_model #(
    parameter int DEPTH = 4
) (
    input  wire logic              i_clk,
    input  wire logic              i_clr,
    input  wire dtc_pkg::dtc_cpu_t i_cpu,
    output logic                   o_full,
    output logic [7:0]             o_wrs,
    output logic [7:0]             o_tags,
    output logic [7:0]             o_forces
);
    import dtc_pkg::*;
    // Full rises with the last fitting write, so the block sees it one edge later
    assign o_full = (o_wrs + 8'(i_cpu.fifo_wr)) >= 8'(DEPTH);
    always_ff @(posedge i_clk) begin
        if (i_clr) begin
            o_wrs <= 8'h00;
            o_tags <= 8'h00;
            o_forces <= 8'h00;
        end else begin
            if (i_cpu.fifo_wr && o_wrs < 8'(DEPTH)) o_wrs <= o_wrs + 8'h01;
            if (i_cpu.brk_tag) o_tags <= o_tags + 8'h01;
            if (i_cpu.brk_force) o_forces <= o_forces + 8'h01;
        end
    end
endmodule : dtc_cpu_model

// [dtc_debug_trigger_control.sv]
// Debug trigger control: control register, run sequencer, break requests
`timescale 1ns/1ns

module dtc_debug_trigger_control (
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    input  wire logic                  i_ce,
    input  wire dtc_pkg::dtc_ahb_req_t i_ahb,
    output dtc_pkg::dtc_ahb_rsp_t      o_ahb,
    input  wire logic                  i_secure,
    input  wire dtc_pkg::dtc_mon_t     i_mon,
    output dtc_pkg::dtc_cpu_t          o_cpu,
    output logic                       o_irq
);
    import dtc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // All state in one record

    typedef struct packed {
        logic                ap_valid;
        logic                ap_write;
        logic [7:0]          ap_addr;
        logic [31:0]         hrdata;
        logic                hreadyout;
        logic [7:0]          ctrl;
        logic                armed_flag;
        dtc_run_t            run;
        logic [DTC_EV_W-1:0] irq_sts;
        logic [DTC_EV_W-1:0] irq_en;
        logic                irq;
        logic                fifo_wr;
        logic                brk_tag;
        logic                brk_force;
    } dtc_state_t;

    dtc_state_t s_r;
    dtc_state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Direction qualified comparator match

    function automatic logic dir_match(
        input logic hit,
        input logic dir_en,
        input logic dir_val,
        input logic rd
    );
        dir_match = hit & (~dir_en | (dir_val == rd));
    endfunction : dir_match

    logic                match_a;
    logic                match_b;
    logic                trig_hit;
    logic                run_on;
    logic                wr_ctrl;
    logic                want_arm;
    logic                stop_run;
    logic                done_ev;
    logic                trig_ev;
    logic [DTC_EV_W-1:0] ev;
    logic [7:0]          wr_byte;

    always_comb begin
        match_a = dir_match(i_mon.hit_a, s_r.ctrl[DTC_BIT_CMP_A_DIR_ENABLE],
                            s_r.ctrl[DTC_BIT_RWA], i_mon.read);
        match_b = dir_match(i_mon.hit_b, s_r.ctrl[DTC_BIT_CMP_B_DIR_ENABLE],
                            s_r.ctrl[DTC_BIT_RWB], i_mon.read);
        // Trigger select only shapes the match; break timing is set below
        case (i_mon.trig_sel)
            DTC_TRG_A:       trig_hit = match_a;
            DTC_TRG_A_OR_B:  trig_hit = match_a | match_b;
            DTC_TRG_A_AND_B: trig_hit = match_a & match_b;
            DTC_TRG_B:       trig_hit = match_b;
            default:         trig_hit = 1'b0;
        endcase
        trig_hit = trig_hit & i_mon.valid;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt           = s_r;
        s_nxt.fifo_wr   = 1'b0;
        s_nxt.brk_tag   = 1'b0;
        s_nxt.brk_force = 1'b0;
        s_nxt.hreadyout = 1'b1;
        wr_ctrl         = 1'b0;
        want_arm        = 1'b0;
        stop_run        = 1'b0;
        done_ev         = 1'b0;
        trig_ev         = 1'b0;
        wr_byte         = i_ahb.hwdata[7:0];

        // Data phase of a write; always accepted, no wait states
        if (s_r.ap_valid && s_r.ap_write) begin
            case (s_r.ap_addr)
                DTC_OFS_CTRL: begin
                    wr_ctrl    = 1'b1;
                    s_nxt.ctrl = wr_byte;
                    if (i_secure) begin
                        s_nxt.ctrl[DTC_BIT_EN] = 1'b0;
                    end
                    want_arm = wr_byte[DTC_BIT_ARM];
                    if (!s_nxt.ctrl[DTC_BIT_ARM] || !s_nxt.ctrl[DTC_BIT_EN]) begin
                        stop_run = 1'b1;
                    end
                end
                DTC_OFS_IRQ_EN: begin
                    s_nxt.irq_en = i_ahb.hwdata[DTC_EV_W-1:0];
                end
                DTC_OFS_IRQ_CLR: begin
                    s_nxt.irq_sts = s_r.irq_sts & ~i_ahb.hwdata[DTC_EV_W-1:0];
                end
                default: begin
                end
            endcase
        end

        if (want_arm) begin
            s_nxt.armed_flag = 1'b1;
        end

        // Run only while enabled and armed
        run_on = s_nxt.ctrl[DTC_BIT_EN] & s_nxt.ctrl[DTC_BIT_ARM];

        if (!run_on || stop_run) begin
            s_nxt.run = DTC_IDLE;
            if (wr_ctrl && !want_arm) begin
                s_nxt.armed_flag = 1'b0;
            end
        end else begin
            case (s_r.run)
                DTC_IDLE: begin
                    s_nxt.run = DTC_ARMED;
                end
                DTC_ARMED: begin
                    // Control writes of the same cycle keep it armed, never trigger
                    if (trig_hit && !wr_ctrl) begin
                        trig_ev       = 1'b1;
                        s_nxt.fifo_wr = 1'b1;
                        if (i_mon.begin_trace) begin
                            s_nxt.run = DTC_CAPTURE;
                        end else begin
                            done_ev = 1'b1;
                        end
                    end
                end
                DTC_CAPTURE: begin
                    if (i_mon.fifo_full) begin
                        done_ev = 1'b1;
                    end else if (i_mon.valid) begin
                        s_nxt.fifo_wr = 1'b1;
                    end
                end
                default: begin
                    s_nxt.run = DTC_IDLE;
                end
            endcase
        end

        if (done_ev) begin
            s_nxt.ctrl[DTC_BIT_ARM] = 1'b0;
            s_nxt.armed_flag        = 1'b0;
            s_nxt.run               = DTC_IDLE;
            if (s_r.ctrl[DTC_BIT_BREAK_ENABLE]) begin
                // Tag bit is looked at only when breaks are on
                s_nxt.brk_tag   = s_r.ctrl[DTC_BIT_TAG];
                s_nxt.brk_force = ~s_r.ctrl[DTC_BIT_TAG];
            end
        end

        // Sticky events: a new event wins over a clear in the same cycle
        ev                       = '0;
        ev[DTC_EV_DONE]          = done_ev;
        ev[DTC_EV_TRIG]          = trig_ev;
        s_nxt.irq_sts            = s_nxt.irq_sts | ev;
        s_nxt.irq                = |(s_nxt.irq_sts & s_nxt.irq_en);

        // Address phase capture
        s_nxt.ap_valid = i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1];
        s_nxt.ap_write = i_ahb.hwrite;
        s_nxt.ap_addr  = i_ahb.haddr[7:0];

        // Read data taken after this cycle's write, so it is never stale
        s_nxt.hrdata = '0;
        if (s_nxt.ap_valid && !i_ahb.hwrite) begin
            case (i_ahb.haddr[7:0])
                DTC_OFS_CTRL: begin
                    s_nxt.hrdata[7:0] = s_nxt.ctrl;
                end
                DTC_OFS_STATUS: begin
                    s_nxt.hrdata[DTC_ST_ARMED]   = s_nxt.armed_flag;
                    s_nxt.hrdata[DTC_ST_CAPTURE] = (s_nxt.run == DTC_CAPTURE);
                end
                DTC_OFS_IRQ_STS: begin
                    s_nxt.hrdata[DTC_EV_W-1:0] = s_nxt.irq_sts;
                end
                DTC_OFS_IRQ_EN: begin
                    s_nxt.hrdata[DTC_EV_W-1:0] = s_nxt.irq_en;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; clock enable low freezes everything

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_r            <= '0;
            s_r.hreadyout  <= 1'b1;
            s_r.ctrl       <= DTC_CTRL_RST;
            s_r.irq_sts    <= DTC_EV_RST;
            s_r.irq_en     <= DTC_EV_RST;
            s_r.run        <= DTC_IDLE;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state record; hresp tied low

    always_comb begin
        o_ahb.hrdata    = s_r.hrdata;
        o_ahb.hreadyout = s_r.hreadyout;
        o_ahb.hresp     = 1'b0;
        o_cpu.fifo_wr   = s_r.fifo_wr;
        o_cpu.brk_tag   = s_r.brk_tag;
        o_cpu.brk_force = s_r.brk_force;
        o_irq           = s_r.irq;
    end

endmodule : dtc_debug_trigger_control

// [dtc_pkg.sv]
// Package for the debug trigger control block: map, fields, types
package dtc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] DTC_OFS_CTRL    = 8'h00;
    localparam logic [7:0] DTC_OFS_STATUS  = 8'h04;
    localparam logic [7:0] DTC_OFS_IRQ_STS = 8'h08;
    localparam logic [7:0] DTC_OFS_IRQ_CLR = 8'h0c;
    localparam logic [7:0] DTC_OFS_IRQ_EN  = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // Control field positions
    localparam int DTC_BIT_EN    = 7;
    localparam int DTC_BIT_ARM   = 6;
    localparam int DTC_BIT_TAG   = 5;
    localparam int DTC_BIT_BREAK_ENABLE = 4;
    localparam int DTC_BIT_RWA   = 3;
    localparam int DTC_BIT_CMP_A_DIR_ENABLE = 2;
    localparam int DTC_BIT_RWB   = 1;
    localparam int DTC_BIT_CMP_B_DIR_ENABLE = 0;

    // Status and interrupt field positions
    localparam int DTC_ST_ARMED   = 0;
    localparam int DTC_ST_CAPTURE = 1;
    localparam int DTC_EV_DONE    = 0;
    localparam int DTC_EV_TRIG    = 1;
    localparam int DTC_EV_W       = 2;

    // Reset values
    localparam logic [7:0]          DTC_CTRL_RST = 8'h00;
    localparam logic [DTC_EV_W-1:0] DTC_EV_RST   = 2'h0;

    // Trigger select codes
    localparam logic [1:0] DTC_TRG_A      = 2'h0;
    localparam logic [1:0] DTC_TRG_A_OR_B = 2'h1;
    localparam logic [1:0] DTC_TRG_A_AND_B = 2'h2;
    localparam logic [1:0] DTC_TRG_B      = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Run sequencer, Gray along idle -> armed -> capture
    typedef enum logic [1:0] {
        DTC_IDLE    = 2'h0,
        DTC_ARMED   = 2'h1,
        DTC_CAPTURE = 2'h3
    } dtc_run_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } dtc_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } dtc_ahb_rsp_t;

    // Bus activity seen by the comparators, same clock
    typedef struct packed {
        logic       valid;
        logic       read;
        logic       hit_a;
        logic       hit_b;
        logic [1:0] trig_sel;
        logic       begin_trace;
        logic       fifo_full;
    } dtc_mon_t;

    typedef struct packed {
        logic fifo_wr;
        logic brk_tag;
        logic brk_force;
    } dtc_cpu_t;

endpackage : dtc_pkg
